// ---- dio_pkg.sv ----
package dio_pkg;

	// ----------------------------------------
	// sizes
	// ----------------------------------------
	localparam int unsigned NUM_IN   = 64;
	localparam int unsigned NUM_OUT  = 64;
	localparam int unsigned NUM_IRQ  = 16;
	localparam int unsigned FILT_W   = 8;

	// ----------------------------------------
	// register byte offsets, 32-byte window
	// ----------------------------------------
	localparam logic [4:0] OFS_IN_LO    = 5'h00;
	localparam logic [4:0] OFS_IN_HI    = 5'h04;
	localparam logic [4:0] OFS_OUT_LO   = 5'h08;
	localparam logic [4:0] OFS_OUT_HI   = 5'h0c;
	localparam logic [4:0] OFS_EDGE_SEL = 5'h10;
	localparam logic [4:0] OFS_IRQ_MASK = 5'h14;
	localparam logic [4:0] OFS_IRQ_STAT = 5'h18;
	localparam logic [4:0] OFS_FILT_LEN = 5'h1c;

	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int unsigned IRQ_LSB  = 0;
	localparam int unsigned FILT_LSB = 0;

	// ----------------------------------------
	// reset values
	// ----------------------------------------
	localparam logic [NUM_OUT-1:0] RST_OUT      = 64'h0000_0000_0000_0000;
	localparam logic [NUM_IRQ-1:0] RST_EDGE_SEL = 16'hffff;
	localparam logic [NUM_IRQ-1:0] RST_IRQ_MASK = 16'h0000;
	localparam logic [NUM_IRQ-1:0] RST_IRQ_STAT = 16'h0000;
	localparam logic [FILT_W-1:0]  RST_FILT_LEN = 8'h00;
	localparam logic [NUM_IN-1:0]  RST_FILTERED = 64'h0000_0000_0000_0000;

	// ----------------------------------------
	// bus codes
	// ----------------------------------------
	localparam logic       HRESP_OKAY = 1'b0;
	localparam logic [1:0] HTRANS_NSQ = 2'h2;

	// ----------------------------------------
	// carriers
	// ----------------------------------------
	typedef struct packed {
		logic [NUM_IN-1:0] level;
	} in_pins_t;

	typedef struct packed {
		logic [NUM_OUT-1:0] o;
		logic [NUM_OUT-1:0] oe;
	} out_pins_t;

endpackage : dio_pkg

// ---- dio_filter.sv ----
`timescale 1ns/1ns
`default_nettype none

module dio_filter
	import dio_pkg::*;
#(
	parameter int unsigned N  = 64,
	parameter int unsigned CW = 8
) (
	// clock and reset
	input  wire logic          hclk,
	input  wire logic          hresetn,
	input  wire logic          ce,
	// samples and setting
	input  wire logic [N-1:0]  raw,
	input  wire logic [CW-1:0] len,
	// result
	output var  logic [N-1:0]  flt
);

	typedef struct packed {
		logic [N-1:0]         flt;
		logic [N-1:0][CW-1:0] cnt;
	} flt_state_t;

	flt_state_t st_ff;
	flt_state_t nxt_st;

	// ----------------------------------------
	// per-bit stability counter
	// ----------------------------------------
	// a change is taken only after it stood len+1 cycles unbroken
	always_comb begin
		nxt_st = st_ff;
		for (int i = 0; i < N; i++) begin
			if (raw[i] == st_ff.flt[i]) begin
				nxt_st.cnt[i] = '0;
			end else if (st_ff.cnt[i] >= len) begin
				nxt_st.flt[i] = raw[i];
				nxt_st.cnt[i] = '0;
			end else begin
				nxt_st.cnt[i] = st_ff.cnt[i] + CW'(1);
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_ff.flt <= RST_FILTERED[N-1:0];
			st_ff.cnt <= '0;
		end else if (ce) begin
			st_ff <= nxt_st;
		end
	end

	assign flt = st_ff.flt;

endmodule : dio_filter

`default_nettype wire

// ---- dio_port.sv ----
// Contract
// - input bit reads 1 when pin low
// - output bit 1 pulls pin low
// - 64 inputs, 16 can interrupt
// - sixteen requests merge onto one line
// - rising or falling edge select on each of the 16 interrupt inputs
// - interrupt enable on each of the 16 interrupt inputs; disabled raises nothing
// - software-set digital filter on every input
// - bus target; host reaches all registers
// - outputs off after reset
`timescale 1ns/1ns
`default_nettype none

module dio_port
	import dio_pkg::*;
(
	// bus clock and reset
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        ce,
	// ahb-lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output var  logic        hreadyout,
	output var  logic        hresp,
	output var  logic [31:0] hrdata,
	// interrupt
	output var  logic        irq,
	// field pins
	input  wire in_pins_t    in_pins,
	output var  out_pins_t   out_pins
);

	typedef struct packed {
		logic                dph_vld;
		logic                dph_wr;
		logic [2:0]          dph_idx;
		logic                rd_wait;
		logic [31:0]         rdata;
		logic [NUM_OUT-1:0]  outd;
		logic [NUM_IRQ-1:0]  edge_sel;
		logic [NUM_IRQ-1:0]  irq_mask;
		logic [NUM_IRQ-1:0]  irq_stat;
		logic [FILT_W-1:0]   filt_len;
		logic [NUM_IRQ-1:0]  prev;
		logic                irq;
	} port_state_t;

	port_state_t        st_ff;
	port_state_t        nxt_st;
	logic [NUM_IN-1:0]  data_in;
	logic [NUM_IN-1:0]  filtered;
	logic [NUM_IRQ-1:0] rise;
	logic [NUM_IRQ-1:0] fall;
	logic [NUM_IRQ-1:0] event_hit;
	logic [NUM_IRQ-1:0] w1c;
	logic               addr_ok;

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [2:0] word_idx(input logic [4:0] ofs);
		word_idx = ofs[4:2];
	endfunction : word_idx

	function automatic logic [31:0] read_mux(
		input logic [2:0]  idx,
		input port_state_t s,
		input logic [63:0] fin
	);
		logic [31:0] r;
		r = 32'h0000_0000;
		unique case (idx)
			word_idx(OFS_IN_LO):    r = fin[31:0];
			word_idx(OFS_IN_HI):    r = fin[63:32];
			word_idx(OFS_OUT_LO):   r = s.outd[31:0];
			word_idx(OFS_OUT_HI):   r = s.outd[63:32];
			word_idx(OFS_EDGE_SEL): r[IRQ_LSB +: NUM_IRQ] = s.edge_sel;
			word_idx(OFS_IRQ_MASK): r[IRQ_LSB +: NUM_IRQ] = s.irq_mask;
			word_idx(OFS_IRQ_STAT): r[IRQ_LSB +: NUM_IRQ] = s.irq_stat;
			word_idx(OFS_FILT_LEN): r[FILT_LSB +: FILT_W] = s.filt_len;
		endcase
		return r;
	endfunction : read_mux

	// ----------------------------------------
	// input path
	// ----------------------------------------
	assign data_in = ~in_pins.level;

	// all 64 channels filtered, 16 of them also feed the irq logic
	dio_filter #(
		.N  (NUM_IN),
		.CW (FILT_W)
	) u_filter (
		.hclk    (hclk),
		.hresetn (hresetn),
		.ce      (ce),
		.raw     (data_in),
		.len     (st_ff.filt_len),
		.flt     (filtered)
	);

	// edge select 1: data 0->1 (pin high-to-low); 0: data 1->0
	assign rise      = filtered[NUM_IRQ-1:0] & ~st_ff.prev;
	assign fall      = ~filtered[NUM_IRQ-1:0] & st_ff.prev;
	assign event_hit = ((st_ff.edge_sel & rise) | (~st_ff.edge_sel & fall))
		& st_ff.irq_mask;

	// ----------------------------------------
	// bus decode
	// ----------------------------------------
	// only the 32-byte window is decoded; upper address bits alias
	assign addr_ok = hsel && hready && (htrans == HTRANS_NSQ);

	assign w1c = (st_ff.dph_vld && st_ff.dph_wr
		&& st_ff.dph_idx == word_idx(OFS_IRQ_STAT))
		? hwdata[IRQ_LSB +: NUM_IRQ] : '0;

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		nxt_st = st_ff;
		nxt_st.prev = filtered[NUM_IRQ-1:0];

		// read takes one wait cycle so the word is a fresh flop value
		if (st_ff.rd_wait) begin
			nxt_st.rdata   = read_mux(st_ff.dph_idx, st_ff, filtered);
			nxt_st.rd_wait = 1'b0;
		end

		// write data phase
		if (st_ff.dph_vld && st_ff.dph_wr) begin
			unique case (st_ff.dph_idx)
				word_idx(OFS_OUT_LO):
					nxt_st.outd[31:0] = hwdata;
				word_idx(OFS_OUT_HI):
					nxt_st.outd[63:32] = hwdata;
				word_idx(OFS_EDGE_SEL):
					nxt_st.edge_sel = hwdata[IRQ_LSB +: NUM_IRQ];
				word_idx(OFS_IRQ_MASK):
					nxt_st.irq_mask = hwdata[IRQ_LSB +: NUM_IRQ];
				word_idx(OFS_FILT_LEN):
					nxt_st.filt_len = hwdata[FILT_LSB +: FILT_W];
				default: begin
				end
			endcase
		end

		// sticky pending, set wins over the one-to-clear
		nxt_st.irq_stat = (st_ff.irq_stat & ~w1c) | event_hit;
		nxt_st.irq      = |(nxt_st.irq_stat & nxt_st.irq_mask);

		// address phase accepted when the previous one completes
		if (hready) begin
			nxt_st.dph_vld = addr_ok;
			nxt_st.dph_wr  = hwrite;
			nxt_st.dph_idx = haddr[4:2];
			nxt_st.rd_wait = addr_ok && !hwrite;
		end
	end

	// ----------------------------------------
	// state register
	// ----------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_ff.dph_vld  <= 1'b0;
			st_ff.dph_wr   <= 1'b0;
			st_ff.dph_idx  <= 3'h0;
			st_ff.rd_wait  <= 1'b0;
			st_ff.rdata    <= 32'h0000_0000;
			st_ff.outd     <= RST_OUT;
			st_ff.edge_sel <= RST_EDGE_SEL;
			st_ff.irq_mask <= RST_IRQ_MASK;
			st_ff.irq_stat <= RST_IRQ_STAT;
			st_ff.filt_len <= RST_FILT_LEN;
			st_ff.prev     <= RST_FILTERED[NUM_IRQ-1:0];
			st_ff.irq      <= 1'b0;
		end else if (ce) begin
			st_ff <= nxt_st;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	// stalls while frozen so no write data phase is dropped
	assign hreadyout = ce && !st_ff.rd_wait;
	assign hresp     = HRESP_OKAY;
	assign hrdata    = st_ff.rdata;
	assign irq       = st_ff.irq;

	// open collector: enable pulls the pin low, never drives high
	// one driver for the whole carrier, o is tied low
	assign out_pins = '{o: '0, oe: st_ff.outd};

endmodule : dio_port

`default_nettype wire

// ---- dio_port_assertions.sv ----
`timescale 1ns/1ns
`default_nettype none
module dio_port_assertions
	import dio_pkg::*;
(
	// bus side
	input wire logic        hclk,
	input wire logic        hresetn,
	input wire logic        ce,
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic [31:0] hwdata,
	input wire logic        hready,
	input wire logic        hreadyout,
	input wire logic        hresp,
	// irq and pins
	input wire logic        irq,
	input wire out_pins_t   out_pins
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	logic tk;
	assign tk = hsel & hready & ce & (htrans == HTRANS_NSQ);
	property p_okay; hresp == HRESP_OKAY; endproperty
	a_okay: assert property (p_okay) else $error("bad hresp");
	property p_rd; tk & !hwrite |=> !hreadyout ##1 hreadyout; endproperty
	a_rd: assert property (p_rd) else $error("read wait");
	property p_wr; tk & hwrite |=> hreadyout; endproperty
	a_wr: assert property (p_wr) else $error("write wait");
	property p_ce; !ce |-> !hreadyout; endproperty
	a_ce: assert property (p_ce) else $error("stall");
	property p_rst; $rose(hresetn) |-> out_pins.oe == '0; endproperty
	a_rst: assert property (p_rst) else $error("outputs on");
	property p_oc; out_pins.o == '0; endproperty
	a_oc: assert property (p_oc) else $error("drives high");
	property p_wo;
		tk & hwrite & (haddr[4:0] == OFS_OUT_LO) ##1 hreadyout
		|=> out_pins.oe[31:0] == $past(hwdata);
	endproperty
	a_wo: assert property (p_wo) else $error("oe lo");
	property p_if; $fell(irq) |-> $past(tk & hwrite, 2); endproperty
	a_if: assert property (p_if) else $error("irq fell");
endmodule : dio_port_assertions
bind dio_port dio_port_assertions i_chk (.hclk(hclk), .hresetn(hresetn),
	.ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
	.hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
	.irq(irq), .out_pins(out_pins));
`default_nettype wire

// ---- dio_field.sv ----
`timescale 1ns/1ns
`default_nettype none
module dio_field
	import dio_pkg::*;
(
	// 1 = contact closes pin to ground
	input  wire logic [63:0] pull_low,
	input  wire out_pins_t   out_pins,
	// pin levels
	output var  in_pins_t    in_pins,
	output var  logic [63:0] out_lvl
);
	// open inputs sit high on the board pull-up
	assign in_pins.level = ~pull_low;
	// our pull-up wins unless the collector sinks
	assign out_lvl = ~out_pins.oe;
endmodule : dio_field
`default_nettype wire

// ---- tb.sv ----
`timescale 1ns/1ns
`default_nettype none
module tb;
	import dio_pkg::*;
	logic        hclk = 1'b0;
	logic        hresetn = 1'b0;
	logic        ce = 1'b1;
	logic        hsel = 1'b0;
	logic        hwrite = 1'b0;
	logic [1:0]  htrans = 2'h0;
	logic [2:0]  hsize = 3'h2;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [63:0] low = 64'h0;
	logic        hreadyout;
	logic        hresp;
	logic        irq;
	logic [31:0] hrdata;
	logic [63:0] lvl;
	in_pins_t    in_pins;
	out_pins_t   out_pins;
	int          n_fail = 0;
	int          checks_done = 0;
	always #20 hclk = ~hclk;
	dio_port i_dio_port (.hclk(hclk), .hresetn(hresetn), .ce(ce),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .irq(irq),
		.in_pins(in_pins), .out_pins(out_pins));
	dio_field i_dio_field (.pull_low(low), .out_pins(out_pins),
		.in_pins(in_pins), .out_lvl(lvl));
	task automatic results;
		$display("checks %0d fails %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : results
	task automatic chk(input logic [63:0] g, input logic [63:0] e);
		checks_done++;
		if (g !== e) begin
			n_fail++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask : chk
	// hready looked at on the falling edge, taken at the next rising one
	// read data taken mid-cycle too, where it stands for the edge
	task automatic rdy(output logic [31:0] d);
		int k;
		d = 32'h0;
		for (k = 0; k < 50; k++) begin
			@(negedge hclk);
			if (hreadyout === 1'b1) break;
		end
		d = hrdata;
		if (k == 50) begin
			n_fail++;
			$display("[ERR] %0t bus hang", $time);
			results();
		end
		@(posedge hclk);
	endtask : rdy
	task automatic xfer(input logic w, input logic [4:0] a,
		input logic [31:0] d, output logic [31:0] q);
		hsel <= 1'b1;
		htrans <= HTRANS_NSQ;
		hwrite <= w;
		haddr <= {27'h0, a};
		rdy(q);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		rdy(q);
	endtask : xfer
	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		logic [31:0] q;
		xfer(1'b1, a, d, q);
	endtask : wr
	task automatic rd(input logic [4:0] a, input logic [31:0] e);
		logic [31:0] q;
		xfer(1'b0, a, 32'h0, q);
		chk(64'(q), 64'(e));
	endtask : rd
	task automatic chk_irq(input logic e);
		repeat (2) @(posedge hclk);
		@(negedge hclk);
		chk(64'(irq), 64'(e));
		@(posedge hclk);
	endtask : chk_irq
	initial begin
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		@(negedge hclk);
		chk(out_pins.oe, 64'h0);
		@(posedge hclk);
		rd(OFS_OUT_LO, 32'h0);
		rd(OFS_OUT_HI, 32'h0);
		rd(OFS_EDGE_SEL, 32'h0000_ffff);
		rd(OFS_IRQ_MASK, 32'h0);
		rd(OFS_IRQ_STAT, 32'h0);
		rd(OFS_FILT_LEN, 32'h0);
		$display("test reset done");
		wr(OFS_OUT_LO, 32'ha5a5_0f0f);
		wr(OFS_OUT_HI, 32'h8000_0001);
		@(negedge hclk);
		chk(lvl, ~64'h8000_0001_a5a5_0f0f);
		@(posedge hclk);
		rd(OFS_OUT_HI, 32'h8000_0001);
		$display("test outputs done");
		low <= 64'h8000_0000_f000_0001;
		repeat (8) @(posedge hclk);
		rd(OFS_IN_LO, 32'hf000_0001);
		wr(OFS_IN_LO, 32'h0);
		rd(OFS_IN_LO, 32'hf000_0001);
		rd(OFS_IN_HI, 32'h8000_0000);
		$display("test inputs done");
		low <= 64'h0;
		wr(OFS_FILT_LEN, 32'h4);
		wr(OFS_IRQ_MASK, 32'h3);
		wr(OFS_EDGE_SEL, 32'h1);
		repeat (10) @(posedge hclk);
		// three cycles is short of the five the filter needs
		low <= 64'h1;
		repeat (3) @(posedge hclk);
		low <= 64'h0;
		repeat (10) @(posedge hclk);
		rd(OFS_IN_LO, 32'h0);
		rd(OFS_IRQ_STAT, 32'h0);
		low <= 64'h1_0006;
		repeat (10) @(posedge hclk);
		rd(OFS_IN_LO, 32'h1_0006);
		rd(OFS_IRQ_STAT, 32'h0);
		chk_irq(1'b0);
		low <= 64'h1;
		repeat (10) @(posedge hclk);
		chk_irq(1'b1);
		rd(OFS_IRQ_STAT, 32'h3);
		wr(OFS_IRQ_STAT, 32'h1);
		rd(OFS_IRQ_STAT, 32'h2);
		chk_irq(1'b1);
		wr(OFS_IRQ_MASK, 32'h0);
		chk_irq(1'b0);
		wr(OFS_IRQ_MASK, 32'h3);
		chk_irq(1'b1);
		wr(OFS_IRQ_STAT, 32'h2);
		chk_irq(1'b0);
		$display("test interrupts done");
		// frozen filter must not count the pin change while ce is low
		ce <= 1'b0;
		low <= 64'h0;
		repeat (10) @(posedge hclk);
		@(negedge hclk);
		chk(64'(hreadyout), 64'h0);
		@(posedge hclk);
		ce <= 1'b1;
		rd(OFS_IN_LO, 32'h1);
		repeat (10) @(posedge hclk);
		rd(OFS_IN_LO, 32'h0);
		$display("test enable done");
		wr(OFS_OUT_LO, 32'hffff_ffff);
		hresetn <= 1'b0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		@(negedge hclk);
		chk(out_pins.oe, 64'h0);
		@(posedge hclk);
		rd(OFS_OUT_LO, 32'h0);
		rd(OFS_IRQ_MASK, 32'h0);
		$display("test bus reset done");
		results();
	end
endmodule : tb
`default_nettype wire
